/* File: rtl/eepc_top.sv */
// eeprom program/erase controller with apb register access
// ----------------------------------------
// Functional notes
// (RL1) 512-byte array, programmed with internal pump
// (RL2) reset copies nonvolatile config and divider
// (RL3) 35us timebase from divider, selectable reference
// (RL4) software loads divider before any operation
// (RL5) armed security blocks 16-byte window writes
// (RL6) armed: no config, block, bulk changes
// (RL7) four 128-byte blocks, protect bits inhibit
// (RL8) protect applies after reset or config read
// (RL9) divider lock freezes divider copies permanently
// (RL10) erased bits read one, blank reads ff
// (RL11) program only clears bits written zero
// (RL12) erase sets bits, byte up to array
// (RL13) software never reprograms a programmed bit
// (RL14) self-timed mode clears enable after timer
// (RL15) software sequence: select, latch, write, enable
// (RL16) self-timed: poll enable, then clear latch
// (RL17) program only unprotected bytes or config
// (RL18) select bits choose program/erase kind
// (RL19) enable refused without latch and address
// (RL20) clearing latch with enable clears enable only
// (RL21) self-timed length counts timebase ticks
// ----------------------------------------
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "eepc_cfg.svh"
module eepc_top #(
    parameter int        DIV_W      = 16,
    parameter logic [7:0] NV_CFG_INIT = 8'hFF,
    parameter logic [15:0] NV_DIV_INIT = 16'hFFFF
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        osc_tick,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             pump_on_q
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0]            ctl_q;
    logic [7:0]            shadow_q;
    logic [7:0]            nv_cfg_q;
    logic [15:0]           nv_div_q;
    logic [15:0]           div_q;
    logic [7:0]            sys_cfg_q;
    logic                  valid_q;
    eepc_pkg::eepc_latch_t lat_q;
    logic [15:0]           auto_cnt_q;
    logic                  init_q;
    logic                  tick;
    logic                  wr;
    logic                  rd;
    logic                  arr_hit;
    logic [8:0]            arr_idx;
    logic [7:0]            arr_rd;
    logic                  pgm_fall;
    logic                  go;
    logic                  armed;
    logic                  div_locked;
    logic                  nv_ok;
    logic                  erasing;
    eepc_pkg::eepc_op_t    op;

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    assign arr_hit = paddr >= `EEPC_OFF_ARRAY_BASE
                     && paddr < `EEPC_OFF_ARRAY_BASE + 12'(`EEPC_ARRAY_BYTES);
    assign arr_idx = paddr[8:0];
    assign op      = eepc_pkg::eepc_op_t'({ctl_q[`EEPC_CTL_SEL_HI], ctl_q[`EEPC_CTL_SEL_LO]});
    assign armed      = !shadow_q[`EEPC_CFG_ARM];
    assign div_locked = !div_q[8 + `EEPC_DIV_LOCK];
    assign erasing    = op != eepc_pkg::EEPC_BYTE_PGM;

    // ----------------------------------------
    // register selects
    // ----------------------------------------
    // one decode per register, with the array window kept out explicitly
    logic                  sel_ctl;
    logic                  sel_shadow;
    logic                  sel_nv_cfg;
    logic                  sel_div_hi;
    logic                  sel_div_lo;
    logic                  sel_nv_div_hi;
    logic                  sel_nv_div_lo;
    logic                  sel_sys;
    logic                  cfg_refresh;

    assign sel_ctl       = !arr_hit && paddr == `EEPC_OFF_NV_CONTROL;
    assign sel_shadow    = !arr_hit && paddr == `EEPC_OFF_CFG_SHADOW;
    assign sel_nv_cfg    = !arr_hit && paddr == `EEPC_OFF_NV_CFG;
    assign sel_div_hi    = !arr_hit && paddr == `EEPC_OFF_DIV_HIGH;
    assign sel_div_lo    = !arr_hit && paddr == `EEPC_OFF_DIV_LOW;
    assign sel_nv_div_hi = !arr_hit && paddr == `EEPC_OFF_NV_DIV_HIGH;
    assign sel_nv_div_lo = !arr_hit && paddr == `EEPC_OFF_NV_DIV_LOW;
    assign sel_sys       = !arr_hit && paddr == `EEPC_OFF_SYS_CFG2;
    // after the reset copy, only a read of the nv copy moves new protect bits into effect
    assign cfg_refresh   = rd && sel_nv_cfg; // [RL8]

    // ----------------------------------------
    // reset load of volatile copies
    // ----------------------------------------
    // async reset takes constants; the nv values are copied on the first edge after release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shadow_q <= '0;
        end else if (init_q) begin
            shadow_q <= nv_cfg_q; // [RL2]
        end else if (cfg_refresh) begin
            shadow_q[3:0] <= nv_cfg_q[3:0]; // [RL8]
        end else if (wr && sel_shadow) begin
            shadow_q[7:5] <= pwdata[7:5];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= `EEPC_DIV_RESET;
        end else if (init_q) begin
            div_q <= nv_div_q; // [RL2] [RL9]
        end else if (wr && !div_locked && sel_div_hi) begin
            div_q[15:8] <= pwdata[7:0]; // [RL9]
        end else if (wr && !div_locked && sel_div_lo) begin
            div_q[7:0] <= pwdata[7:0]; // [RL9]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sys_cfg_q <= '0;
        end else if (wr && sel_sys) begin
            sys_cfg_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // address/data latch
    // ----------------------------------------
    // writes during the high-voltage pulse cannot retarget the cell being changed
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lat_q   <= '0;
            valid_q <= 1'b0;
        end else if (!ctl_q[`EEPC_CTL_LAT]) begin
            valid_q <= 1'b0;
        end else if (wr && !ctl_q[`EEPC_CTL_PGM]) begin
            if (arr_hit || sel_nv_cfg || sel_nv_div_hi
                || sel_nv_div_lo) begin
                lat_q.addr      <= arr_idx; // [RL19]
                lat_q.data      <= pwdata[7:0];
                lat_q.nv_cfg    <= sel_nv_cfg;
                lat_q.nv_div_hi <= sel_nv_div_hi;
                lat_q.nv_div_lo <= sel_nv_div_lo;
                valid_q         <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // control register and self-timed cycle
    // ----------------------------------------
    // the timer clear is taken first so a write in the same cycle cannot keep enable alive
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_q <= '0;
        end else if (ctl_q[`EEPC_CTL_PGM] && ctl_q[`EEPC_CTL_AUTO] && tick
                     && auto_cnt_q + 16'h0001 >= `EEPC_AUTO_TICKS) begin
            ctl_q[`EEPC_CTL_PGM] <= 1'b0; // [RL14] [RL21]
        end else if (wr && sel_ctl) begin
            ctl_q[7:3]            <= pwdata[7:3];
            ctl_q[`EEPC_CTL_AUTO] <= pwdata[`EEPC_CTL_AUTO];
            // latch holds while enable is on, even when both are cleared together
            if (!ctl_q[`EEPC_CTL_PGM])
                ctl_q[`EEPC_CTL_LAT] <= pwdata[`EEPC_CTL_LAT]; // [RL20]
            ctl_q[`EEPC_CTL_PGM] <= pwdata[`EEPC_CTL_PGM]
                                    && ctl_q[`EEPC_CTL_LAT] && valid_q; // [RL19]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            auto_cnt_q <= '0;
        end else if (!ctl_q[`EEPC_CTL_PGM]) begin
            auto_cnt_q <= '0;
        end else if (tick) begin
            auto_cnt_q <= auto_cnt_q + 16'h0001; // [RL21]
        end
    end

    eepc_timebase #(
        .DIV_W (DIV_W)
    ) u_tb (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .osc_tick (osc_tick),
        .ref_sel  (sys_cfg_q[`EEPC_SYS_REF_SEL]),
        .divider  (div_q),
        .run      (ctl_q[`EEPC_CTL_PGM]),
        .tick_q   (tick)
    ); // [RL3]

    // ----------------------------------------
    // commit at end of high-voltage phase
    // ----------------------------------------
    // the cell change is applied when enable falls, after the pump had the full window
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pump_on_q <= 1'b0;
        end else begin
            pump_on_q <= ctl_q[`EEPC_CTL_PGM]; // [RL1]
        end
    end

    assign pgm_fall = pump_on_q && !ctl_q[`EEPC_CTL_PGM];
    assign go       = pgm_fall && valid_q && !lat_q.nv_cfg && !lat_q.nv_div_hi
                      && !lat_q.nv_div_lo; // [RL17] [RL18]
    assign nv_ok    = pgm_fall && valid_q && (op == eepc_pkg::EEPC_BYTE_PGM
                      || op == eepc_pkg::EEPC_BYTE_ERASE);

    // nv registers take byte program and erase only; block and bulk leave them alone
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            nv_cfg_q <= NV_CFG_INIT;
            nv_div_q <= NV_DIV_INIT;
        end else if (nv_ok) begin
            if (lat_q.nv_cfg && !armed)
                nv_cfg_q <= erasing ? `EEPC_ERASED_BYTE : nv_cfg_q & lat_q.data; // [RL6]
            if (lat_q.nv_div_hi && !div_locked)
                nv_div_q[15:8] <= erasing ? `EEPC_ERASED_BYTE
                                          : nv_div_q[15:8] & lat_q.data; // [RL9]
            if (lat_q.nv_div_lo && !div_locked)
                nv_div_q[7:0] <= erasing ? `EEPC_ERASED_BYTE
                                         : nv_div_q[7:0] & lat_q.data; // [RL9]
        end
    end

    eepc_array #(
        .BYTES (`EEPC_ARRAY_BYTES)
    ) u_arr (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .rd_addr  (arr_idx),
        .rd_data  (arr_rd),
        .go       (go),
        .op       (op),
        .addr     (lat_q.addr),
        .data     (lat_q.data),
        .blk_prot (shadow_q[3:0]),
        .secure   (armed)
    ); // [RL7] [RL5] [RL12]

    // ----------------------------------------
    // apb read path, no wait states
    // ----------------------------------------
    // read data is captured in setup so it stands for the whole access cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= '0;
                if (arr_hit) begin
                    // a latched byte reads back its pending data
                    prdata[7:0] <= (ctl_q[`EEPC_CTL_LAT] && valid_q && arr_idx == lat_q.addr)
                                   ? lat_q.data : arr_rd; // [RL10]
                end else begin
                    case (paddr)
                        `EEPC_OFF_NV_CONTROL:  prdata[7:0] <= ctl_q;
                        `EEPC_OFF_CFG_SHADOW:  prdata[7:0] <= shadow_q;
                        `EEPC_OFF_NV_CFG:      prdata[7:0] <= nv_cfg_q;
                        `EEPC_OFF_DIV_HIGH:    prdata[7:0] <= div_q[15:8];
                        `EEPC_OFF_DIV_LOW:     prdata[7:0] <= div_q[7:0];
                        `EEPC_OFF_NV_DIV_HIGH: prdata[7:0] <= nv_div_q[15:8];
                        `EEPC_OFF_NV_DIV_LOW:  prdata[7:0] <= nv_div_q[7:0];
                        `EEPC_OFF_SYS_CFG2:    prdata[7:0] <= sys_cfg_q;
                        default:               pslverr <= 1'b1;
                    endcase
                end
            end
        end
    end
endmodule

/* File: pkg/eepc_cfg.svh */
// constants for the eeprom program/erase controller
`ifndef EEPC_CFG_SVH
`define EEPC_CFG_SVH

// ----------------------------------------
// register byte offsets on apb
// ----------------------------------------
`define EEPC_OFF_NV_CONTROL     12'h000
`define EEPC_OFF_CFG_SHADOW     12'h004
`define EEPC_OFF_NV_CFG         12'h008
`define EEPC_OFF_DIV_HIGH       12'h00C
`define EEPC_OFF_DIV_LOW        12'h010
`define EEPC_OFF_NV_DIV_HIGH    12'h014
`define EEPC_OFF_NV_DIV_LOW     12'h018
`define EEPC_OFF_SYS_CFG2       12'h01C
`define EEPC_OFF_ARRAY_BASE     12'h800
`define EEPC_ARRAY_BYTES        512

// ----------------------------------------
// control register fields
// ----------------------------------------
`define EEPC_CTL_PGM            0
`define EEPC_CTL_AUTO           1
`define EEPC_CTL_LAT            2
`define EEPC_CTL_SEL_LO         3
`define EEPC_CTL_SEL_HI         4
`define EEPC_CTL_OFF            5
`define EEPC_CTL_SPARE          7

// ----------------------------------------
// configuration fields and secure window
// ----------------------------------------
`define EEPC_CFG_ARM            4
`define EEPC_DIV_LOCK           7
`define EEPC_SYS_REF_SEL        0
`define EEPC_SEC_LO             9'h0F0
`define EEPC_SEC_HI             9'h0FF
`define EEPC_ERASED_BYTE        8'hFF

// ----------------------------------------
// timing
// ----------------------------------------
`define EEPC_TB_US              35
`define EEPC_AUTO_TICKS         16'h0100
`define EEPC_DIV_RESET          16'h0007

`endif

/* File: pkg/eepc_pkg.sv */
// types for the eeprom program/erase controller
package eepc_pkg;
    typedef enum logic [1:0] {
        EEPC_BYTE_PGM,
        EEPC_BYTE_ERASE,
        EEPC_BLOCK_ERASE,
        EEPC_BULK_ERASE
    } eepc_op_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
        logic       nv_cfg;
        logic       nv_div_hi;
        logic       nv_div_lo;
    } eepc_latch_t;
endpackage

/* File: rtl/eepc_timebase.sv */
// 35 us tick generator from the selected reference
`timescale 1ns/1ps
`include "eepc_cfg.svh"
module eepc_timebase #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             osc_tick,
    input  wire logic             ref_sel,
    input  wire logic [DIV_W-1:0] divider,
    input  wire logic             run,
    output logic                  tick_q
);
    logic [DIV_W-1:0] cnt_q;
    logic             ref_en;

    // bus clock counts every edge, oscillator only on its tick
    assign ref_en = ref_sel ? 1'b1 : osc_tick;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (!run) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (ref_en) begin
                if (cnt_q + 1'b1 >= divider) begin
                    cnt_q  <= '0;
                    tick_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
endmodule

/* File: rtl/eepc_array.sv */
// 512 byte nonvolatile array model with program and erase
`timescale 1ns/1ps
`include "eepc_cfg.svh"
module eepc_array #(
    parameter int BYTES = `EEPC_ARRAY_BYTES
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic [$clog2(BYTES)-1:0] rd_addr,
    output logic [7:0]                    rd_data,
    input  wire logic                     go,
    input  wire eepc_pkg::eepc_op_t       op,
    input  wire logic [$clog2(BYTES)-1:0] addr,
    input  wire logic [7:0]               data,
    input  wire logic [3:0]               blk_prot,
    input  wire logic                     secure
);
    localparam int AW = $clog2(BYTES);
    logic [7:0] mem_q [BYTES];

    assign rd_data = mem_q[rd_addr];

    // per entry update; block protect and the secure window are filtered here for every op
    for (genvar i = 0; i < BYTES; i++) begin : g_cell
        localparam logic [AW-1:0] IA = AW'(i);
        logic in_sec;
        logic blk_ok;
        assign in_sec = (IA >= AW'(`EEPC_SEC_LO)) && (IA <= AW'(`EEPC_SEC_HI));
        assign blk_ok = !blk_prot[IA[AW-1:AW-2]] && !(secure && in_sec); // [RL5] [RL7]
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                mem_q[i] <= `EEPC_ERASED_BYTE; // [RL10]
            end else if (go && blk_ok) begin
                case (op)
                    eepc_pkg::EEPC_BYTE_PGM: begin
                        if (IA == addr) mem_q[i] <= mem_q[i] & data; // [RL11]
                    end
                    eepc_pkg::EEPC_BYTE_ERASE: begin
                        if (IA == addr) mem_q[i] <= `EEPC_ERASED_BYTE; // [RL12]
                    end
                    eepc_pkg::EEPC_BLOCK_ERASE: begin
                        if (IA[AW-1:AW-2] == addr[AW-1:AW-2] && !secure)
                            mem_q[i] <= `EEPC_ERASED_BYTE; // [RL6] [RL12]
                    end
                    default: begin
                        if (!secure) mem_q[i] <= `EEPC_ERASED_BYTE; // [RL6] [RL12]
                    end
                endcase
            end
        end
    end
endmodule

/* File: verification/eepc_top_props.sv */
// concurrent checks on the eeprom controller ports
`timescale 1ns/1ps
module eepc_top_props (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pump_on_q
);
    logic mapped;
    logic ctl_wr;
    logic ctl_set;
    assign mapped = (paddr <= 12'h01C && paddr[1:0] == 2'h0) || paddr[11:9] == 3'h4;
    assign ctl_wr = pready && pwrite && paddr == 12'h000;
    assign ctl_set = ctl_wr && pwdata[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ctl_clear;
        ctl_wr && !pwdata[0];
    endsequence
    a_ready_access:
        assert property (s_setup |=> pready) else $error("ready late");
    a_ready_single:
        assert property (pready |-> psel && penable ##1 !pready) else $error("ready stray");
    a_err_unmapped:
        assert property (pready && !mapped |-> pslverr) else $error("no slave error");
    a_err_mapped:
        assert property (pready && mapped |-> !pslverr) else $error("false slave error");
    a_err_pulse:
        assert property (pslverr |-> pready) else $error("error without ready");
    a_rdata_high:
        assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
            else $error("read data upper bits set");
    a_pump_cause:
        assert property ($rose(pump_on_q) |-> $past(ctl_set, 2)) else $error("pump rose alone");
    a_pump_clear:
        assert property (s_ctl_clear |-> ##2 !pump_on_q) else $error("pump stayed on");
endmodule

/* File: verification/eepc_apb_host.sv */
// apb master that stands in for the cpu side
`timescale 1ns/1ps
module eepc_apb_host (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        req,
    input  wire logic        req_write,
    input  wire logic [11:0] req_addr,
    input  wire logic [31:0] req_wdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic             done,
    output logic [31:0]      rdata,
    output logic             err
);
    // done holds until req drops, so one request never runs twice
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b0;
        end else if (psel && penable && pready) begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b1;
            rdata <= prdata;
            err <= pslverr;
            // released lines must not keep looking valid
            paddr <= ~paddr;
            pwdata <= ~pwdata;
        end else if (psel) begin
            penable <= 1'b1;
        end else if (!req) begin
            done <= 1'b0;
        end else if (!done) begin
            psel <= 1'b1;
            pwrite <= req_write;
            paddr <= req_addr;
            pwdata <= req_wdata;
        end
    end
endmodule

/* File: verification/tb_eepc_top.sv */
// self-checking bench for the eeprom program/erase controller
`timescale 1ns/1ps
`include "eepc_cfg.svh"
module tb_eepc_top;
    localparam int DIV = 3;
    localparam int TICKS = `EEPC_AUTO_TICKS;
    logic        clk, sys_rst, osc_tick, req, req_write, done, err;
    logic        psel, penable, pwrite, pready, pslverr, pump_on_q;
    logic [11:0] req_addr, paddr;
    logic [31:0] req_wdata, pwdata, prdata, rdata;
    logic [1:0]  osc_cnt;
    int          n_fail, tests_run, cycles, len;

    eepc_top #(.NV_CFG_INIT(8'hE4), .NV_DIV_INIT(16'(DIV))) i_dut (
        .clk(clk), .sys_rst(sys_rst), .osc_tick(osc_tick), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pump_on_q(pump_on_q));
    eepc_apb_host i_host (
        .clk(clk), .sys_rst(sys_rst), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .done(done), .rdata(rdata), .err(err));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // oscillator reference: one pulse every four bus cycles
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 2'h1;
        osc_tick <= (osc_cnt == 2'h3);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        req <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        do @(posedge clk);
        while (done !== 1'b1);
        q = rdata;
        req <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, {24'h00_0000, d}, q);
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0000_0000, q);
        chk(nm, q, {24'h00_0000, e});
    endtask
    // latch, write target, enable, then end the cycle by hand or by timer
    task automatic op(input logic [1:0] sel, input logic au, input logic [11:0] a,
                      input logic [7:0] d);
        logic [7:0] ctl;
        logic       on;
        ctl = {3'h0, sel, 1'b1, au, 1'b0};
        len = 1;
        wr(12'h000, ctl);
        wr(a, d);
        wr(12'h000, ctl | 8'h01);
        @(posedge clk);
        on = pump_on_q;
        if (au) begin
            while (pump_on_q === 1'b1 && len < 4000) begin
                @(posedge clk);
                len++;
            end
            rc("auto_done", 12'h000, ctl);
        end else begin
            repeat (40) @(posedge clk);
            // one write drops enable while the latch holds, since enable was on, and keeps the select bits the commit uses
            wr(12'h000, ctl & 8'hFA);
            if (on)
                rc("latch_kept", 12'h000, ctl);
        end
        wr(12'h000, 8'h00);
    endtask

    task automatic t_refuse();
        wr(12'h000, 8'h01);
        rc("no_latch", 12'h000, 8'h00);
        wr(12'h000, 8'h04);
        wr(12'h000, 8'h05);
        rc("no_addr", 12'h000, 8'h04);
        wr(12'h000, 8'h00);
    endtask
    task automatic t_reset_values();
        logic [31:0] q;
        rc("shadow", 12'h004, 8'hE4);
        wr(12'h004, 8'h0F);
        rc("prot_ro", 12'h004, 8'h04);
        rc("div_hi", 12'h00C, 8'h00);
        rc("div_lo", 12'h010, 8'(DIV));
        rc("blank_lo", 12'h800, 8'hFF);
        rc("blank_hi", 12'h9FF, 8'hFF);
        apb(1'b0, 12'h020, 32'h0000_0000, q);
        chk("unmapped", err, 1'h1);
    endtask
    task automatic t_program();
        op(2'h0, 1'b0, 12'h805, 8'hF5);
        rc("pgm_first", 12'h805, 8'hF5);
        op(2'h0, 1'b0, 12'h805, 8'hBF);
        rc("pgm_second", 12'h805, 8'hB5);
    endtask
    task automatic t_auto();
        wr(12'h01C, 8'h01);
        op(2'h1, 1'b1, 12'h805, 8'h00);
        rc("byte_erase", 12'h805, 8'hFF);
        chk("bus_len", len >= TICKS * DIV - 16 && len <= TICKS * DIV + 16, 1'h1);
        wr(12'h01C, 8'h00);
        op(2'h0, 1'b1, 12'h806, 8'h00);
        rc("auto_pgm", 12'h806, 8'h00);
        chk("osc_len", len >= TICKS * DIV * 4 - 16 && len <= TICKS * DIV * 4 + 16, 1'h1);
    endtask
    task automatic t_secure();
        op(2'h0, 1'b0, 12'h8F0, 8'h00);
        rc("secure_rd", 12'h8F0, 8'hFF);
        op(2'h0, 1'b0, 12'h008, 8'h00);
        rc("cfg_fixed", 12'h008, 8'hE4);
        op(2'h2, 1'b0, 12'h806, 8'h00);
        rc("no_block", 12'h806, 8'h00);
        op(2'h3, 1'b0, 12'h806, 8'h00);
        rc("no_bulk", 12'h806, 8'h00);
        op(2'h0, 1'b0, 12'h900, 8'h00);
        rc("prot_blk", 12'h900, 8'hFF);
        wr(12'h00C, 8'h80);
        rc("div_frozen", 12'h00C, 8'h00);
        op(2'h0, 1'b0, 12'h018, 8'h00);
        rc("nvdiv_frozen", 12'h018, 8'(DIV));
    endtask
    task automatic t_rereset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        rc("shadow_again", 12'h004, 8'hE4);
        rc("blank_again", 12'h806, 8'hFF);
    endtask

    initial begin
        sys_rst = 1'b1;
        {req, req_write, osc_tick, osc_cnt} = 5'h00;
        req_addr = 12'h000;
        req_wdata = 32'h0000_0000;
        {n_fail, tests_run, cycles} = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_refuse();
        t_reset_values();
        t_program();
        t_auto();
        t_secure();
        t_rereset();
        wrap_up();
    end
endmodule

bind eepc_top eepc_top_props u_props (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pump_on_q(pump_on_q));
